// File: src/positioning_sequencer_leds.sv
// Purpose: plan loop or direct runs, check end position, drive status LEDs
// Assumes: motion unit reports done as a same-clock pulse; pins are async
// Notes:   moves are issued one leg at a time as absolute targets
`timescale 1ns/1ps

module positioning_sequencer_leds #(
    parameter int unsigned PORTS = 2
) (
    // clock and reset
    input  wire logic                          clk_sys_in,
    input  wire logic                          resetn_in,
    // command from the fieldbus master
    input  wire logic                          start_in,
    input  wire logic signed [posseq_pkg::POS_W-1:0] target_in,
    input  wire logic                          loop_wr_in,
    input  wire logic signed [posseq_pkg::POS_W-1:0] loop_length_in,
    input  wire logic                          no_loop_mode_in,
    input  wire logic signed [posseq_pkg::POS_W-1:0] upper_travel_limit_in,
    input  wire logic signed [posseq_pkg::POS_W-1:0] lower_travel_limit_in,
    input  wire logic                          err_clear_in,
    // motion unit and encoder
    input  wire logic signed [posseq_pkg::POS_W-1:0] actual_pos_in,
    input  wire logic signed [posseq_pkg::POS_W-1:0] encoder_pos_in,
    input  wire logic                          move_done_in,
    output logic                               move_start_out,
    output logic signed [posseq_pkg::POS_W-1:0] move_target_out,
    output logic                               busy_out,
    output logic                               refused_out,
    output logic [posseq_pkg::STATUS_W-1:0]    status_word_out,
    // indicator inputs (asynchronous)
    input  wire logic [PORTS-1:0]              port_link_in,
    input  wire logic [PORTS-1:0]              port_activity_in,
    input  wire logic [1:0]                    slave_state_in,
    input  wire logic                          local_fault_in,
    input  wire logic                          wdog_cfg_fault_in,
    input  wire logic                          motor_supply_ok_in,
    input  wire logic                          delivery_state_in,
    // indicators
    output logic [PORTS-1:0]                   port_link_indicators_out,
    output logic                               run_led_out,
    output logic                               err_led_out,
    output logic                               motor_led_out
);
    import posseq_pkg::*;

    localparam int unsigned SW = PORTS * 2 + 6;

    // ---------------- synchronisers for the pin inputs
    logic [SW-1:0] pins, sync1_reg, sync2_reg;
    assign pins = {port_link_in, port_activity_in, slave_state_in,
                   local_fault_in, wdog_cfg_fault_in, motor_supply_ok_in,
                   delivery_state_in};
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end
    logic [PORTS-1:0] lnk_s, act_s;
    slave_state_e     ss_s;
    logic             lf_s, wd_s, mok_s, dlv_s;
    assign {lnk_s, act_s} = sync2_reg[SW-1:6];
    assign ss_s  = slave_state_e'(sync2_reg[5:4]);
    assign lf_s  = sync2_reg[3];
    assign wd_s  = sync2_reg[2];
    assign mok_s = sync2_reg[1];
    assign dlv_s = sync2_reg[0];

    // ---------------- sequencer
    seq_state_e state_reg, state_next;
    logic signed [POS_W-1:0] loop_reg, loop_next;
    logic signed [POS_W-1:0] tgt_reg, tgt_next, mt_reg, mt_next;
    logic ms_reg, ms_next, ref_reg, ref_next, err_reg, err_next;
    logic fwd_noloop_reg, fwd_noloop_next;

    always_comb begin
        state_next      = state_reg;
        loop_next       = loop_reg;
        tgt_next        = tgt_reg;
        mt_next         = mt_reg;
        ms_next         = 1'b0;
        ref_next        = 1'b0;
        err_next        = err_reg;
        fwd_noloop_next = fwd_noloop_reg;
        if (loop_wr_in && state_reg == ST_IDLE)
            loop_next = loop_length_in;
        if (err_clear_in)
            err_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                // idle from reset, so a run can start at once
                if (start_in) begin
                    if (!no_loop_mode_in && loop_reg > 0 &&
                        target_in == upper_travel_limit_in) begin
                        ref_next = 1'b1;
                    end else if (!no_loop_mode_in && loop_reg < 0 &&
                                 target_in == lower_travel_limit_in) begin
                        ref_next = 1'b1;
                    end else begin
                        tgt_next   = target_in;
                        ms_next    = 1'b1;
                        state_next = ST_WAIT1;
                        mt_next    = target_in;
                        fwd_noloop_next = 1'b0;
                        if (no_loop_mode_in) begin
                            fwd_noloop_next = target_in > actual_pos_in;
                            state_next = ST_WAIT2;
                        end else if (loop_reg > 0 &&
                                     target_in > actual_pos_in) begin
                            mt_next = target_in + loop_reg;
                        end else if (loop_reg < 0 &&
                                     target_in < actual_pos_in) begin
                            // final approach from below
                            mt_next = target_in + loop_reg;
                        end else if (fwd_noloop_reg && loop_reg > 0 &&
                                     actual_pos_in - target_in < loop_reg) begin
                            // reverse leg must still be a full loop
                            mt_next = target_in + loop_reg;
                        end else begin
                            state_next = ST_WAIT2;
                        end
                    end
                end
            end
            ST_WAIT1: if (move_done_in) begin
                state_next = ST_RUN2;
            end
            ST_RUN2: begin
                mt_next    = tgt_reg;
                ms_next    = 1'b1;
                state_next = ST_WAIT2;
            end
            ST_WAIT2: if (move_done_in) begin
                state_next = ST_CHECK;
            end
            ST_CHECK: begin
                if (encoder_pos_in != actual_pos_in)
                    err_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg      <= ST_IDLE;
            loop_reg       <= LOOP_RESET;
            tgt_reg        <= '0;
            mt_reg         <= '0;
            ms_reg         <= 1'b0;
            ref_reg        <= 1'b0;
            err_reg        <= 1'b0;
            fwd_noloop_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            loop_reg       <= loop_next;
            tgt_reg        <= tgt_next;
            mt_reg         <= mt_next;
            ms_reg         <= ms_next;
            ref_reg        <= ref_next;
            err_reg        <= err_next;
            fwd_noloop_reg <= fwd_noloop_next;
        end
    end

    logic busy_reg;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            busy_reg <= 1'b0;
        else
            busy_reg <= (state_next != ST_IDLE);
    end

    assign move_start_out  = ms_reg;
    assign move_target_out = mt_reg;
    assign refused_out     = ref_reg;
    assign busy_out        = busy_reg;
    assign status_word_out = STATUS_W'(err_reg) << STATUS_ERR_BIT;

    // ---------------- prescalers: one free-running set keeps LEDs in phase
    function automatic logic [24:0] wrap(input logic [24:0] c,
                                         input int unsigned half);
        return (c >= 25'(half - 1)) ? 25'h0 : c + 25'h1;
    endfunction

    logic [24:0] fl_cnt_reg, pre_cnt_reg, saf_cnt_reg, mot_cnt_reg, slot_cnt_reg;
    logic [24:0] fl_cnt_next, pre_cnt_next, saf_cnt_next, mot_cnt_next;
    logic [24:0] slot_cnt_next;
    logic fl_ph_reg, pre_ph_reg, saf_ph_reg, mot_ph_reg;
    logic fl_ph_next, pre_ph_next, saf_ph_next, mot_ph_next;
    logic [2:0] slot_reg, slot_next;

    always_comb begin
        fl_cnt_next   = wrap(fl_cnt_reg, FLICKER_HALF);
        pre_cnt_next  = wrap(pre_cnt_reg, PREOP_HALF);
        saf_cnt_next  = wrap(saf_cnt_reg, SAFEOP_HALF);
        mot_cnt_next  = wrap(mot_cnt_reg, MOTOR_HALF);
        slot_cnt_next = wrap(slot_cnt_reg, FLASH_SLOT);
        fl_ph_next    = fl_ph_reg ^ (fl_cnt_next == 25'h0);
        pre_ph_next   = pre_ph_reg ^ (pre_cnt_next == 25'h0);
        saf_ph_next   = saf_ph_reg ^ (saf_cnt_next == 25'h0);
        mot_ph_next   = mot_ph_reg ^ (mot_cnt_next == 25'h0);
        slot_next     = slot_reg + {2'b00, (slot_cnt_next == 25'h0)};
    end

    logic [PORTS-1:0] port_led_reg, port_led_next;
    logic run_reg, run_next, errl_reg, errl_next, mot_reg, mot_next;

    always_comb begin
        for (int i = 0; i < PORTS; i++)
            port_led_next[i] = lnk_s[i] & (~act_s[i] | fl_ph_reg);
        unique case (ss_s)
            SS_INIT:   run_next = 1'b0;
            SS_PREOP:  run_next = pre_ph_reg;
            SS_SAFEOP: run_next = saf_ph_reg;
            SS_OP:     run_next = 1'b1;
        endcase
        // double flash: slots 0 and 2 lit; single: slot 0 lit
        if (wd_s)
            errl_next = (slot_reg == 3'h0) || (slot_reg == 3'h2);
        else if (lf_s)
            errl_next = (slot_reg == 3'h0);
        else
            errl_next = 1'b0;
        mot_next = mok_s & (~dlv_s | mot_ph_reg);
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fl_cnt_reg   <= '0;
            pre_cnt_reg  <= '0;
            saf_cnt_reg  <= '0;
            mot_cnt_reg  <= '0;
            slot_cnt_reg <= '0;
            fl_ph_reg    <= 1'b0;
            pre_ph_reg   <= 1'b0;
            saf_ph_reg   <= 1'b0;
            mot_ph_reg   <= 1'b0;
            slot_reg     <= '0;
            port_led_reg <= '0;
            run_reg      <= 1'b0;
            errl_reg     <= 1'b0;
            mot_reg      <= 1'b0;
        end else begin
            fl_cnt_reg   <= fl_cnt_next;
            pre_cnt_reg  <= pre_cnt_next;
            saf_cnt_reg  <= saf_cnt_next;
            mot_cnt_reg  <= mot_cnt_next;
            slot_cnt_reg <= slot_cnt_next;
            fl_ph_reg    <= fl_ph_next;
            pre_ph_reg   <= pre_ph_next;
            saf_ph_reg   <= saf_ph_next;
            mot_ph_reg   <= mot_ph_next;
            slot_reg     <= slot_next;
            port_led_reg <= port_led_next;
            run_reg      <= run_next;
            errl_reg     <= errl_next;
            mot_reg      <= mot_next;
        end
    end

    assign port_link_indicators_out = port_led_reg;
    assign run_led_out   = run_reg;
    assign err_led_out   = errl_reg;
    assign motor_led_out = mot_reg;

    // ---------------- assertions
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    upper_refuse_a: assert property (
        (state_reg == ST_IDLE && start_in && !no_loop_mode_in &&
         loop_reg > 0 && target_in == upper_travel_limit_in)
        |=> refused_out && !move_start_out)
        else $error("run to upper limit not refused");
    lower_refuse_a: assert property (
        (state_reg == ST_IDLE && start_in && !no_loop_mode_in &&
         loop_reg < 0 && target_in == lower_travel_limit_in)
        |=> refused_out && state_reg == ST_IDLE)
        else $error("run to lower limit not refused");
    overrun_leg_a: assert property (
        (state_reg == ST_IDLE && start_in && !no_loop_mode_in &&
         loop_reg > 0 && target_in > actual_pos_in &&
         target_in != upper_travel_limit_in)
        |=> move_start_out && move_target_out == $past(target_in) +
            $past(loop_reg))
        else $error("overrun leg target wrong");
    direct_mode_a: assert property (
        (state_reg == ST_IDLE && start_in && no_loop_mode_in)
        |=> move_start_out && state_reg == ST_WAIT2 &&
            move_target_out == $past(target_in))
        else $error("loopless run not direct");
    final_leg_a: assert property (
        (state_reg == ST_RUN2) |=> move_start_out &&
            move_target_out == tgt_reg)
        else $error("final leg not onto target");
    check_err_a: assert property (
        (state_reg == ST_CHECK && encoder_pos_in != actual_pos_in)
        |=> status_word_out[STATUS_ERR_BIT])
        else $error("encoder mismatch not flagged");
    port_dark_a: assert property (
        (!lnk_s[0]) |=> !port_link_indicators_out[0])
        else $error("port indicator lit without link");
    run_init_a: assert property (
        (ss_s == SS_INIT) [*2] |=> !run_led_out)
        else $error("run indicator lit in init");
    motor_off_a: assert property (
        (!mok_s) |=> !motor_led_out)
        else $error("motor indicator lit when supply bad");
    err_dark_a: assert property (
        (!lf_s && !wd_s) |=> !err_led_out)
        else $error("error indicator lit without fault");

    loop_run_c:   cover property (state_reg == ST_WAIT1 ##1 move_done_in);
    refuse_c:     cover property (refused_out);
    mismatch_c:   cover property (state_reg == ST_CHECK &&
                                  encoder_pos_in != actual_pos_in);
    flicker_c:    cover property (lnk_s[0] && act_s[0] &&
                                  $fell(port_link_indicators_out[0]));
endmodule

// File: pkg/posseq_pkg.sv
// Purpose: constants shared by the positioning sequencer and its indicators
// Assumes: 25 MHz system clock
// Notes:   positions are signed increments of the shaft position
package posseq_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned POS_W           = 32;
    // indicator rates in Hz (2.5 Hz kept as tenths)
    localparam int unsigned FLICKER_HZ      = 10;
    localparam int unsigned PREOP_DHZ       = 25;
    localparam int unsigned SAFEOP_HZ       = 1;
    localparam int unsigned FLASH_HZ        = 1;
    localparam int unsigned MOTOR_FLASH_HZ  = 2;
    // half periods in cycles, rounded down
    localparam int unsigned FLICKER_HALF    = CLK_HZ / (2 * FLICKER_HZ);
    localparam int unsigned PREOP_HALF      = (CLK_HZ * 10) / (2 * PREOP_DHZ);
    localparam int unsigned SAFEOP_HALF     = CLK_HZ / (2 * SAFEOP_HZ);
    localparam int unsigned MOTOR_HALF      = CLK_HZ / (2 * MOTOR_FLASH_HZ);
    // error flash pattern: one 1 Hz period cut into eight 125 ms slots
    localparam int unsigned FLASH_SLOT      = CLK_HZ / (8 * FLASH_HZ);
    localparam int unsigned STATUS_ERR_BIT  = 9;
    localparam int unsigned STATUS_W        = 16;
    localparam logic [POS_W-1:0] LOOP_RESET = 32'hFFFF_FF9C;
    localparam logic [POS_W-1:0] OVERRUN_REF = 32'h0000_0280;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RUN1    = 3'b001,
        ST_WAIT1   = 3'b010,
        ST_RUN2    = 3'b011,
        ST_WAIT2   = 3'b100,
        ST_CHECK   = 3'b101
    } seq_state_e;

    typedef enum logic [1:0] {
        SS_INIT    = 2'b00,
        SS_PREOP   = 2'b01,
        SS_SAFEOP  = 2'b10,
        SS_OP      = 2'b11
    } slave_state_e;
endpackage

// File: tb/motion_unit_model.sv
// Purpose: behavioural motion unit and absolute encoder facing the sequencer
// Assumes: one leg at a time, absolute targets, same clock as the sequencer
// Notes:   encoder offset lets the bench provoke a position mismatch
`timescale 1ns/1ps
module motion_unit_model (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // leg command from the sequencer
    input  wire logic        move_start_in,
    input  wire logic [31:0] move_target_in,
    // bench knobs
    input  wire logic [7:0]  delay_in,
    input  wire logic [31:0] enc_offset_in,
    // position feedback
    output logic [31:0]      actual_pos_out,
    output logic [31:0]      encoder_pos_out,
    output logic             move_done_out
);
    logic [7:0]  cnt_reg;
    logic [31:0] goal_reg;

    // a zero delay would leave the count idle and never answer, so one is the floor
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg        <= 8'h00;
            goal_reg       <= 32'h0000_0000;
            actual_pos_out <= 32'h0000_0000;
            move_done_out  <= 1'b0;
        end else begin
            move_done_out <= 1'b0;
            if (move_start_in) begin
                goal_reg <= move_target_in;
                cnt_reg  <= (delay_in == 8'h00) ? 8'h01 : delay_in;
            end else if (cnt_reg == 8'h01) begin
                actual_pos_out <= goal_reg;
                move_done_out  <= 1'b1;
                cnt_reg        <= 8'h00;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    assign encoder_pos_out = actual_pos_out + enc_offset_in;
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the positioning sequencer and indicators
// Assumes: 25 MHz clock; slow blink rates are beyond the run length
// Notes:   steady indicators, and the error flash only in its first slot
`timescale 1ns/1ps
module tb;
    import posseq_pkg::*;
    logic clk_sys_in, resetn_in, start_in, loop_wr_in, no_loop_mode_in;
    logic err_clear_in, local_fault_in, wdog_cfg_fault_in;
    logic motor_supply_ok_in, delivery_state_in;
    logic [POS_W-1:0] target_in, loop_length_in, upper_in, lower_in;
    logic [POS_W-1:0] actual_pos, encoder_pos, move_target_out, enc_off;
    logic move_done, move_start_out, busy_out, refused_out;
    logic [STATUS_W-1:0] status_word_out;
    logic [1:0] port_link_in, port_activity_in, slave_state_in, leds_out;
    logic run_led_out, err_led_out, motor_led_out, ref_seen;
    logic [7:0] delay;
    logic [POS_W-1:0] legs [4];
    int failures, num_checks, n_legs, cycles;

    positioning_sequencer_leds dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .start_in(start_in), .target_in(target_in),
        .loop_wr_in(loop_wr_in), .loop_length_in(loop_length_in),
        .no_loop_mode_in(no_loop_mode_in),
        .upper_travel_limit_in(upper_in), .lower_travel_limit_in(lower_in),
        .err_clear_in(err_clear_in), .actual_pos_in(actual_pos),
        .encoder_pos_in(encoder_pos), .move_done_in(move_done),
        .move_start_out(move_start_out), .move_target_out(move_target_out),
        .busy_out(busy_out), .refused_out(refused_out),
        .status_word_out(status_word_out), .port_link_in(port_link_in),
        .port_activity_in(port_activity_in), .slave_state_in(slave_state_in),
        .local_fault_in(local_fault_in), .wdog_cfg_fault_in(wdog_cfg_fault_in),
        .motor_supply_ok_in(motor_supply_ok_in),
        .delivery_state_in(delivery_state_in),
        .port_link_indicators_out(leds_out), .run_led_out(run_led_out),
        .err_led_out(err_led_out), .motor_led_out(motor_led_out));

    motion_unit_model partner (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .move_start_in(move_start_out), .move_target_in(move_target_out),
        .delay_in(delay), .enc_offset_in(enc_off),
        .actual_pos_out(actual_pos), .encoder_pos_out(encoder_pos),
        .move_done_out(move_done));

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // leg log and refusal watch
    always @(posedge clk_sys_in) begin
        if (move_start_out === 1'b1 && n_legs < 4) begin
            legs[n_legs] = move_target_out;
            n_legs++;
        end
        if (refused_out === 1'b1) ref_seen = 1'b1;
        cycles++;
        if (cycles >= 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic set_loop(input logic [31:0] len);
        @(posedge clk_sys_in);
        loop_wr_in     <= 1'b1;
        loop_length_in <= len;
        @(posedge clk_sys_in);
        loop_wr_in <= 1'b0;
    endtask

    // one command; legs and refusal judged once busy has dropped
    task automatic run(input logic [31:0] t, input int en,
                       input logic [31:0] e0, input logic [31:0] e1,
                       input logic er);
        int k;
        n_legs   = 0;
        ref_seen = 1'b0;
        @(posedge clk_sys_in);
        start_in  <= 1'b1;
        target_in <= t;
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        repeat (3) @(negedge clk_sys_in);
        k = 0;
        while (busy_out !== 1'b0 && k < 2000) begin
            @(negedge clk_sys_in);
            k++;
        end
        chk(n_legs, en);
        if (en > 0) chk(legs[0], e0);
        if (en > 1) chk(legs[1], e1);
        chk({31'h0, ref_seen}, {31'h0, er});
    endtask

    task automatic led_case(input logic [1:0] lk, input logic [1:0] ss,
                            input logic ok, input logic [4:0] exp);
        @(posedge clk_sys_in);
        port_link_in       <= lk;
        slave_state_in     <= ss;
        motor_supply_ok_in <= ok;
        repeat (6) @(negedge clk_sys_in);
        chk({leds_out, run_led_out, err_led_out, motor_led_out}, exp);
    endtask

    initial begin
        resetn_in = 1'b0;
        start_in = 1'b0;
        loop_wr_in = 1'b0;
        no_loop_mode_in = 1'b0;
        err_clear_in = 1'b0;
        target_in = 32'h0;
        loop_length_in = 32'h0;
        // every target lies within the limits: no run presses on a block
        upper_in = 32'h0000_C350;
        lower_in = 32'hFFFF_EC78;
        enc_off = 32'h0;
        delay = 8'h02;
        port_link_in = 2'b00;
        port_activity_in = 2'b00;
        slave_state_in = 2'b00;
        local_fault_in = 1'b0;
        wdog_cfg_fault_in = 1'b0;
        motor_supply_ok_in = 1'b0;
        delivery_state_in = 1'b0;
        failures = 0;
        num_checks = 0;
        n_legs = 0;
        cycles = 0;
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(negedge clk_sys_in);
        chk({busy_out, status_word_out}, 17'h0);
        // delivery loop is negative: upward target is a direct forward leg
        run(32'h3E8, 1, 32'h3E8, 32'h0, 1'b0);
        run(32'h1F4, 2, 32'h190, 32'h1F4, 1'b0);
        run(32'hFFFF_EC78, 0, 32'h0, 32'h0, 1'b1);
        set_loop(32'h0000_00C8);
        run(32'h7D0, 2, 32'h898, 32'h7D0, 1'b0);
        run(32'h0, 1, 32'h0, 32'h0, 1'b0);
        run(32'h0000_C350, 0, 32'h0, 32'h0, 1'b1);
        @(posedge clk_sys_in);
        no_loop_mode_in <= 1'b1;
        run(32'h3E8, 1, 32'h3E8, 32'h0, 1'b0);
        run(32'h1F4, 1, 32'h1F4, 32'h0, 1'b0);
        run(32'h258, 1, 32'h258, 32'h0, 1'b0);
        @(posedge clk_sys_in);
        no_loop_mode_in <= 1'b0;
        run(32'h226, 2, 32'h2EE, 32'h226, 1'b0);
        // slow partner plus encoder offset
        delay   = 8'h28;
        enc_off = 32'h3;
        run(32'h2BC, 2, 32'h384, 32'h2BC, 1'b0);
        chk(status_word_out, 16'h0200);
        enc_off = 32'h0;
        @(posedge clk_sys_in);
        err_clear_in <= 1'b1;
        @(posedge clk_sys_in);
        err_clear_in <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk(status_word_out, 16'h0000);
        // reference case: the loop is the overrun of 5/8 of a rotation
        set_loop(OVERRUN_REF);
        run(32'h3E8, 2, 32'h3E8 + OVERRUN_REF, 32'h3E8, 1'b0);
        led_case(2'b00, 2'b00, 1'b0, 5'b00000);
        led_case(2'b01, 2'b11, 1'b1, 5'b01101);
        led_case(2'b10, 2'b11, 1'b0, 5'b10100);
        // the first flash slot is lit for both fault kinds
        @(posedge clk_sys_in);
        local_fault_in <= 1'b1;
        led_case(2'b00, 2'b00, 1'b0, 5'b00010);
        @(posedge clk_sys_in);
        local_fault_in    <= 1'b0;
        wdog_cfg_fault_in <= 1'b1;
        led_case(2'b00, 2'b00, 1'b0, 5'b00010);
        summarize();
    end
endmodule
